//--- hdl/ctrb_consts.vh
// Address map, field positions, reset values and scale of the threshold bank
`ifndef CTRB_CONSTS_VH
`define CTRB_CONSTS_VH

// Threshold registers
`define CTRB_ADDR_OV_CLR 8'h18
`define CTRB_ADDR_OV_SET 8'h19
`define CTRB_ADDR_UV_SET 8'h1A
`define CTRB_ADDR_UV_CLR 8'h1B
`define CTRB_ADDR_MISMATCH 8'h1C
`define CTRB_ADDR_HOLE 8'h1D
`define CTRB_ADDR_AUX_OT 8'h1E
`define CTRB_ADDR_AUX_UT 8'h1F
`define CTRB_THR_BASE 8'h18
`define CTRB_THR_LAST 8'h1F

// Result block: cells at 0x40..0x4B, total 0x4C, highest 0x4D, lowest 0x4E
`define CTRB_ADDR_RES_HI 4'h4
`define CTRB_RES_TOTAL 4'hC
`define CTRB_RES_HIGH 4'hD
`define CTRB_RES_LOW 4'hE
`define CTRB_RES_LAST 4'hE

// Auxiliary, self-check and control registers
`define CTRB_ADDR_AUX1 8'h50
`define CTRB_ADDR_AUX2 8'h51
`define CTRB_ADDR_SELF 8'h52
`define CTRB_ADDR_SCAN 8'h60
`define CTRB_ADDR_CELL_EN 8'h61
`define CTRB_ADDR_FMEA 8'h62
`define CTRB_ADDR_FMEA_MASK 8'h63
`define CTRB_ADDR_OV_ALERT 8'h64
`define CTRB_ADDR_UV_ALERT 8'h65
`define CTRB_ADDR_MISC_ALERT 8'h66

// Scan control fields
`define CTRB_SCAN_STROBE 0
`define CTRB_SCAN_AUX1_EN 1
`define CTRB_SCAN_AUX2_EN 2
`define CTRB_SCAN_SELF_EN 3
`define CTRB_SCAN_GLOB_UT_EN 4
`define CTRB_SCAN_GLOB_OT_EN 5

// Aux and self-check register fields below the 12-bit value
`define CTRB_AUX_VALID 3
`define CTRB_AUX_OT_EN 1
`define CTRB_AUX_UT_EN 0

// Misc alert fields
`define CTRB_MISC_OT 0
`define CTRB_MISC_UT 1
`define CTRB_MISC_MISMATCH 2

// Check byte fields
`define CTRB_CHK_ALARM 0
`define CTRB_CHK_PEC_ERR 1

// Scan channel codes
`define CTRB_CHAN_AUX1 4'hC
`define CTRB_CHAN_AUX2 4'hD
`define CTRB_CHAN_SELF 4'hE

// Reset values
`define CTRB_RST_THR 12'h000
`define CTRB_RST_CELL_EN 12'hFFF
`define CTRB_RST_FMEA_MASK 8'h00

// Voltage scale: full code 0xFFF stands for 5.0000 V at most
`define CTRB_VFS_MV 5000
`define CTRB_CODE_MAX 12'hFFF

`endif

//--- hdl/ctrb_result_mem.v
// Result store: one write port, one registered read port
`timescale 1ns/100ps
module ctrb_result_mem #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk_sys,
    input wire rstn,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data_q
);

reg [WIDTH-1:0] mem [0:DEPTH-1];

// Array write, no reset on the storage
always @(posedge clk_sys) begin
    if (wr_en) begin
        mem[wr_addr] <= wr_data;
    end
end

// Read data always comes from a flip-flop
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        rd_data_q <= {WIDTH{1'b0}};
    end else begin
        rd_data_q <= mem[rd_addr];
    end
end

endmodule // ctrb_result_mem

//--- hdl/ctrb_top.v
// Cell threshold register bank with scan sequencer and result registers
//
// Summary of operation
// - Threshold registers are 16 bits with the 12-bit value in 15:4.
// - Low four threshold bits are dropped on write and read as zero.
// - Voltage thresholds decode at 0x18 to 0x1C.
// - Temperature thresholds decode at 0x1E and 0x1F; 0x1D is not one.
// - Full threshold code stands for at most 5.0000 volts.
// - Writing the scan strobe bit as 1 while idle starts a scan of enabled channels.
// - Aux and self-check results are valid only after an enabled scan.
// - Aux and self-check result registers present a 12-bit conversion.
// - Results for cells 1-12, total, highest, lowest; disabled cells skip.
// - Per-input hot and cold enables gate alarms with global enables.
// - Failure-mode flags each have a host read-write mask bit.
// - Reads return a check byte with alarm summary and packet error flag.
`timescale 1ns/100ps
`include "ctrb_consts.vh"
module ctrb_top #(
    parameter NCELL = 12,
    parameter NFMEA = 8
) (
    input wire clk_sys,
    input wire rstn,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [15:0] reg_rdata,
    output reg [7:0] check_byte_q,
    output reg rd_valid_q,
    input wire pec_error,
    output reg adc_start_q,
    output reg [3:0] adc_chan_q,
    input wire adc_done,
    input wire [11:0] adc_result,
    input wire [NFMEA-1:0] fmea_event,
    output wire scan_busy,
    output reg alarm_q
);

localparam ST_IDLE = 3'd0;
localparam ST_PICK = 3'd1;
localparam ST_WAIT = 3'd2;
localparam ST_TOTAL = 3'd3;
localparam ST_HIGH = 3'd4;
localparam ST_LOW = 3'd5;

reg [11:0] thr_q [0:7];
reg [5:0] scan_cfg_q;
reg [NCELL-1:0] cell_en_q, ov_q, uv_q;
reg [11:0] aux1_q, aux2_q, self_q, high_q, low_q;
reg aux1_valid_q, aux2_valid_q, self_valid_q;
reg [1:0] aux1_en_q, aux2_en_q;
reg [NFMEA-1:0] fmea_q, fmea_mask_q;
reg hot_q, cold_q, mismatch_q, any_cell_q, rd_mem_q, mem_we;
reg [2:0] state_q;
reg [3:0] chan_q, mem_wa;
reg [15:0] total_q, reg_rd_q, mem_wd, rd_mux;
wire [15:0] mem_rd;
wire [11:0] ov_clr, ov_set, uv_set, uv_clr, mm_lvl, ot_lvl, ut_lvl;
wire [2:0] thr_idx;
wire thr_hit, scan_go, hot_now, cold_now, alarm_now;
integer i;
assign thr_idx = reg_addr[2:0];
// Address 0x1D is a hole in the threshold window
assign thr_hit = (reg_addr >= `CTRB_THR_BASE) && (reg_addr <= `CTRB_THR_LAST)
    && (reg_addr != `CTRB_ADDR_HOLE);
assign ov_clr = thr_q[0];
assign ov_set = thr_q[1];
assign uv_set = thr_q[2];
assign uv_clr = thr_q[3];
assign mm_lvl = thr_q[4];
assign ot_lvl = thr_q[6];
assign ut_lvl = thr_q[7];
assign scan_busy = (state_q != ST_IDLE);
// Strobe ignored while a scan is already running
assign scan_go = reg_wr && (reg_addr == `CTRB_ADDR_SCAN)
    && reg_wdata[`CTRB_SCAN_STROBE] && !scan_busy;
// Threshold storage keeps only bits 15:4 of the written word
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        for (i = 0; i < 8; i = i + 1) begin
            thr_q[i] <= `CTRB_RST_THR;
        end
    end else if (reg_wr && thr_hit) begin
        thr_q[thr_idx] <= reg_wdata[15:4];
    end
end
// Configuration registers written by the host
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        scan_cfg_q <= 6'h00;
        cell_en_q <= `CTRB_RST_CELL_EN;
        aux1_en_q <= 2'b00;
        aux2_en_q <= 2'b00;
        fmea_mask_q <= `CTRB_RST_FMEA_MASK;
    end else if (reg_wr) begin
        case (reg_addr)
            `CTRB_ADDR_SCAN: scan_cfg_q <= {reg_wdata[5:1], 1'b0};
            `CTRB_ADDR_CELL_EN: cell_en_q <= reg_wdata[NCELL-1:0];
            `CTRB_ADDR_AUX1: aux1_en_q <= reg_wdata[1:0];
            `CTRB_ADDR_AUX2: aux2_en_q <= reg_wdata[1:0];
            `CTRB_ADDR_FMEA_MASK:
                fmea_mask_q <= reg_wdata[NFMEA-1:0];
            default: scan_cfg_q <= scan_cfg_q;
        endcase
    end
end
// Failure flags: sticky, host writes 0 to clear, a new event wins
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        fmea_q <= {NFMEA{1'b0}};
    end else if (reg_wr && (reg_addr == `CTRB_ADDR_FMEA)) begin
        fmea_q <= (fmea_q & reg_wdata[NFMEA-1:0]) | fmea_event;
    end else begin
        fmea_q <= fmea_q | fmea_event;
    end
end
// Scan sequencer: cells by enable, then aux 1, aux 2, self-check
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        state_q <= ST_IDLE;
        chan_q <= 4'h0;
        adc_start_q <= 1'b0;
        adc_chan_q <= 4'h0;
        total_q <= 16'h0000;
        high_q <= 12'h000;
        low_q <= 12'h000;
        any_cell_q <= 1'b0;
    end else begin
        adc_start_q <= 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (scan_go) begin
                    state_q <= ST_PICK;
                    chan_q <= 4'h0;
                    total_q <= 16'h0000;
                    high_q <= 12'h000;
                    low_q <= `CTRB_CODE_MAX;
                    any_cell_q <= 1'b0;
                end
            end
            ST_PICK: begin
                if ((chan_q < NCELL && cell_en_q[chan_q])
                    || (chan_q == `CTRB_CHAN_AUX1
                        && scan_cfg_q[`CTRB_SCAN_AUX1_EN])
                    || (chan_q == `CTRB_CHAN_AUX2
                        && scan_cfg_q[`CTRB_SCAN_AUX2_EN])
                    || (chan_q == `CTRB_CHAN_SELF
                        && scan_cfg_q[`CTRB_SCAN_SELF_EN])) begin
                    adc_start_q <= 1'b1;
                    adc_chan_q <= chan_q;
                    state_q <= ST_WAIT;
                end else if (chan_q == `CTRB_CHAN_SELF) begin
                    state_q <= ST_TOTAL;
                end else begin
                    chan_q <= chan_q + 4'h1;
                end
            end
            ST_WAIT: begin
                if (adc_done) begin
                    if (chan_q < NCELL) begin
                        total_q <= total_q + {4'h0, adc_result};
                        any_cell_q <= 1'b1;
                        if (adc_result > high_q) begin
                            high_q <= adc_result;
                        end
                        if (adc_result < low_q) begin
                            low_q <= adc_result;
                        end
                    end
                    if (chan_q == `CTRB_CHAN_SELF) begin
                        state_q <= ST_TOTAL;
                    end else begin
                        chan_q <= chan_q + 4'h1;
                        state_q <= ST_PICK;
                    end
                end
            end
            ST_TOTAL: state_q <= ST_HIGH;
            ST_HIGH: state_q <= ST_LOW;
            ST_LOW: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
        endcase
    end
end
// Result store write port, fed by the sequencer only
always @* begin
    mem_we = 1'b0;
    mem_wa = chan_q;
    mem_wd = {adc_result, 4'h0};
    case (state_q)
        ST_WAIT: mem_we = adc_done && (chan_q < NCELL);
        ST_TOTAL: begin
            mem_we = 1'b1;
            mem_wa = `CTRB_RES_TOTAL;
            mem_wd = total_q;
        end
        ST_HIGH: begin
            mem_we = 1'b1;
            mem_wa = `CTRB_RES_HIGH;
            mem_wd = {(any_cell_q ? high_q : 12'h000), 4'h0};
        end
        ST_LOW: begin
            mem_we = 1'b1;
            mem_wa = `CTRB_RES_LOW;
            mem_wd = {(any_cell_q ? low_q : 12'h000), 4'h0};
        end
        default: mem_we = 1'b0;
    endcase
end
// Aux and self-check results with validity once converted
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        aux1_q <= 12'h000;
        aux2_q <= 12'h000;
        self_q <= 12'h000;
        aux1_valid_q <= 1'b0;
        aux2_valid_q <= 1'b0;
        self_valid_q <= 1'b0;
    end else if (state_q == ST_WAIT && adc_done) begin
        if (chan_q == `CTRB_CHAN_AUX1) begin
            aux1_q <= adc_result;
            aux1_valid_q <= 1'b1;
        end
        if (chan_q == `CTRB_CHAN_AUX2) begin
            aux2_q <= adc_result;
            aux2_valid_q <= 1'b1;
        end
        if (chan_q == `CTRB_CHAN_SELF) begin
            self_q <= adc_result;
            self_valid_q <= 1'b1;
        end
    end
end
// Cell alerts with hysteresis against thresholds on the same scale
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        ov_q <= {NCELL{1'b0}};
        uv_q <= {NCELL{1'b0}};
        mismatch_q <= 1'b0;
    end else begin
        if (state_q == ST_WAIT && adc_done && chan_q < NCELL) begin
            if (adc_result > ov_set) begin
                ov_q[chan_q] <= 1'b1;
            end else if (adc_result < ov_clr) begin
                ov_q[chan_q] <= 1'b0;
            end
            if (adc_result < uv_set) begin
                uv_q[chan_q] <= 1'b1;
            end else if (adc_result > uv_clr) begin
                uv_q[chan_q] <= 1'b0;
            end
        end
        if (state_q == ST_TOTAL) begin
            mismatch_q <= any_cell_q && ((high_q - low_q) > mm_lvl);
        end
    end
end
// Temperature alarms need both the input enable and the global enable
assign hot_now = (aux1_valid_q && aux1_en_q[`CTRB_AUX_OT_EN]
        && aux1_q <= ot_lvl)
    || (aux2_valid_q && aux2_en_q[`CTRB_AUX_OT_EN] && aux2_q <= ot_lvl);
assign cold_now = (aux1_valid_q && aux1_en_q[`CTRB_AUX_UT_EN]
        && aux1_q >= ut_lvl)
    || (aux2_valid_q && aux2_en_q[`CTRB_AUX_UT_EN] && aux2_q >= ut_lvl);
// Registered temperature flags and alarm summary
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        hot_q <= 1'b0;
        cold_q <= 1'b0;
        alarm_q <= 1'b0;
    end else begin
        hot_q <= hot_now && scan_cfg_q[`CTRB_SCAN_GLOB_OT_EN];
        cold_q <= cold_now && scan_cfg_q[`CTRB_SCAN_GLOB_UT_EN];
        alarm_q <= alarm_now;
    end
end
// Alarm summary: any cell alert, temperature, mismatch, unmasked failure
assign alarm_now = (|ov_q) || (|uv_q) || hot_q || cold_q || mismatch_q
    || (|(fmea_q & ~fmea_mask_q));
// Register read mux for the non-result registers
always @* begin
    rd_mux = 16'h0000;
    if (thr_hit) begin
        rd_mux = {thr_q[thr_idx], 4'h0};
    end else begin
        case (reg_addr)
            `CTRB_ADDR_AUX1: rd_mux = {aux1_q, aux1_valid_q, 1'b0,
                aux1_en_q};
            `CTRB_ADDR_AUX2: rd_mux = {aux2_q, aux2_valid_q, 1'b0,
                aux2_en_q};
            `CTRB_ADDR_SELF: rd_mux = {self_q, self_valid_q, 3'b000};
            `CTRB_ADDR_SCAN: rd_mux = {10'h000, scan_cfg_q[5:1], scan_busy};
            `CTRB_ADDR_CELL_EN: rd_mux = {4'h0, cell_en_q};
            `CTRB_ADDR_FMEA: rd_mux = {8'h00, fmea_q};
            `CTRB_ADDR_FMEA_MASK: rd_mux = {8'h00, fmea_mask_q};
            `CTRB_ADDR_OV_ALERT: rd_mux = {4'h0, ov_q};
            `CTRB_ADDR_UV_ALERT: rd_mux = {4'h0, uv_q};
            `CTRB_ADDR_MISC_ALERT: rd_mux = {13'h0000, mismatch_q, cold_q,
                hot_q};
            default: rd_mux = 16'h0000;
        endcase
    end
end
// Read capture with the check byte
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        reg_rd_q <= 16'h0000;
        rd_mem_q <= 1'b0;
        rd_valid_q <= 1'b0;
        check_byte_q <= 8'h00;
    end else begin
        rd_valid_q <= reg_rd;
        if (reg_rd) begin
            reg_rd_q <= rd_mux;
            rd_mem_q <= (reg_addr[7:4] == `CTRB_ADDR_RES_HI)
                && (reg_addr[3:0] <= `CTRB_RES_LAST);
            check_byte_q <= 8'h00;
            check_byte_q[`CTRB_CHK_ALARM] <= alarm_now;
            check_byte_q[`CTRB_CHK_PEC_ERR] <= pec_error;
        end
    end
end

assign reg_rdata = rd_mem_q ? mem_rd : reg_rd_q;

// Result store, one word per cell plus total, highest and lowest
ctrb_result_mem #(.WIDTH(16), .DEPTH(16), .AW(4)) u_result_mem (
    .clk_sys(clk_sys), .rstn(rstn), .wr_en(mem_we), .wr_addr(mem_wa),
    .wr_data(mem_wd), .rd_addr(reg_addr[3:0]), .rd_data_q(mem_rd)
);

endmodule // ctrb_top

//--- tb/ctrb_adc_model.sv
// Conversion front end model answering each start with one code
`timescale 1ns/100ps
module ctrb_adc_model (
    input wire clk_sys,
    input wire rstn,
    input wire adc_start_q,
    input wire [3:0] adc_chan_q,
    input wire slow,
    input wire [11:0] base,
    output reg adc_done,
    output reg [11:0] adc_result
);
    integer wait_q;
    // Prompt or slow delay, code shown only in the done cycle
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wait_q <= 0;
            adc_done <= 1'b0;
            adc_result <= 12'hA5A;
        end else begin
            adc_done <= 1'b0;
            adc_result <= ~adc_result; // Not held outside done
            if (adc_start_q)
                wait_q <= slow ? 7 : 1;
            else if (wait_q > 1)
                wait_q <= wait_q - 1;
            else if (wait_q == 1) begin
                wait_q <= 0;
                adc_done <= 1'b1;
                adc_result <= base ^ {3{adc_chan_q}};
            end
        end
    end
endmodule // ctrb_adc_model

//--- tb/ctrb_chk.sv
// Concurrent checks on the ports of the threshold register bank
`timescale 1ns/100ps
module ctrb_chk (
    input wire clk_sys,
    input wire rstn,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire [7:0] check_byte_q,
    input wire rd_valid_q,
    input wire pec_error,
    input wire adc_start_q,
    input wire [3:0] adc_chan_q,
    input wire scan_busy
);
    // Threshold window without the hole
    wire thr_sel = (reg_addr[7:3] == 5'h03) && (reg_addr != 8'h1D);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Write to a threshold, then read of the same place
    sequence s_thr_write;
        reg_wr && thr_sel;
    endsequence
    sequence s_same_read;
        reg_rd && reg_addr == $past(reg_addr, 2);
    endsequence
    a_read_valid: assert property (reg_rd |=> rd_valid_q)
        else $error("read not answered");
    a_valid_pulse: assert property (!reg_rd |=> !rd_valid_q)
        else $error("valid without read");
    a_pec_copy: assert property (reg_rd |=>
        check_byte_q[1] == $past(pec_error)) else $error("pec flag");
    a_check_spare: assert property (rd_valid_q |->
        check_byte_q[7:2] == 6'h00) else $error("check byte spare");
    a_thr_nibble: assert property (reg_rd && reg_addr[7:3] == 5'h03
        |=> reg_rdata[3:0] == 4'h0) else $error("low nibble set");
    a_hole_zero: assert property (reg_rd && reg_addr == 8'h1D
        |=> reg_rdata == 16'h0000) else $error("hole not zero");
    a_thr_readback: assert property (s_thr_write ##2 s_same_read
        |=> reg_rdata == ($past(reg_wdata, 3) & 16'hFFF0))
        else $error("threshold readback");
    a_scan_start: assert property (reg_wr && reg_addr == 8'h60
        && reg_wdata[0] && !scan_busy |=> scan_busy)
        else $error("scan not started");
    a_start_busy: assert property (adc_start_q |->
        scan_busy ##1 !adc_start_q) else $error("start outside scan");
    a_chan_range: assert property (adc_start_q |->
        adc_chan_q <= 4'hE) else $error("bad channel");
    a_scan_bound: assert property ($rose(scan_busy) |->
        ##[1:1000] !scan_busy) else $error("scan hangs");
endmodule // ctrb_chk

//--- tb/testbench.sv
// Self-checking bench for the cell threshold register bank
`timescale 1ns/100ps
module testbench;
    reg clk_sys = 1'b0;
    reg rstn = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [15:0] reg_wdata = 16'h0000;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg pec_error = 1'b0;
    reg [7:0] fmea_event = 8'h00;
    reg slow = 1'b0;
    reg [11:0] base = 12'h000;
    wire [15:0] reg_rdata;
    wire [7:0] check_byte_q;
    wire rd_valid_q, adc_start_q, adc_done, scan_busy, alarm_q;
    wire [3:0] adc_chan_q;
    wire [11:0] adc_result;
    integer failures = 0;
    integer checks_done = 0;
    integer cyc = 0;
    integer starts = 0;
    integer i, p, n, sum, hi, lo;
    reg [31:0] seed = 32'h00017C62;
    reg [15:0] rd_q, v, cfg;
    reg [7:0] chk_q;
    reg [11:0] en, c, ovx, uvx;
    ctrb_top i_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .check_byte_q(check_byte_q),
        .rd_valid_q(rd_valid_q), .pec_error(pec_error),
        .adc_start_q(adc_start_q), .adc_chan_q(adc_chan_q),
        .adc_done(adc_done), .adc_result(adc_result),
        .fmea_event(fmea_event), .scan_busy(scan_busy), .alarm_q(alarm_q));
    ctrb_adc_model i_adc (.clk_sys(clk_sys), .rstn(rstn),
        .adc_start_q(adc_start_q), .adc_chan_q(adc_chan_q), .slow(slow),
        .base(base), .adc_done(adc_done), .adc_result(adc_result));
    // Clock
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    // Cycle ceiling and count of conversion starts
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (adc_start_q === 1'b1)
            starts = starts + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            end_of_test;
        end
    end
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task chk(input [15:0] e, input [15:0] g, input [7:0] a);
        begin
            checks_done = checks_done + 1;
            if (e !== g) begin
                failures = failures + 1;
                $display("[FAIL] item %h expected %h seen %h", a, e, g);
            end
        end
    endtask
    task wr(input [7:0] a, input [15:0] d);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk_sys);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input pe);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_rd <= 1'b1;
            pec_error <= pe;
            @(posedge clk_sys);
            reg_rd <= 1'b0;
            pec_error <= 1'b0;
            #1;
            rd_q = reg_rdata;
            chk_q = check_byte_q;
            chk(16'h0001, {15'h0000, rd_valid_q}, a);
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d failures %0d", checks_done, failures);
            if (failures == 0 && checks_done > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        for (i = 8'h18; i < 8'h20; i = i + 1) begin
            rd(i[7:0], 1'b0);
            chk(16'h0000, rd_q, i[7:0]);
            seed = xs(seed);
            v = (i == 8'h1F) ? 16'hFFFF : seed[15:0];
            wr(i[7:0], v);
            rd(i[7:0], 1'b0);
            v = (i == 8'h1D) ? 16'h0000 : (v & 16'hFFF0);
            chk(v, rd_q, i[7:0]);
        end
        seed = xs(seed);
        wr(8'h63, {8'h00, seed[7:0]});
        rd(8'h63, 1'b0);
        chk({8'h00, seed[7:0]}, rd_q, 8'h63);
        wr(8'h63, 16'h0004);
        @(posedge clk_sys);
        fmea_event <= 8'h04;
        @(posedge clk_sys);
        fmea_event <= 8'h00;
        rd(8'h62, 1'b1);
        chk(16'h0004, rd_q, 8'h62);
        chk(16'h0002, {8'h00, chk_q}, 8'hC0);
        wr(8'h63, 16'h0000);
        rd(8'h62, 1'b0);
        chk(16'h0001, {8'h00, chk_q}, 8'hC1);
        chk(16'h0001, {15'h0000, alarm_q}, 8'hA0);
        wr(8'h62, 16'h0000);
        rd(8'h62, 1'b0);
        chk(16'h0000, rd_q, 8'h62);
        chk(16'h0000, {8'h00, chk_q}, 8'hC2);
        chk(16'h0000, {15'h0000, alarm_q}, 8'hA1);
        rd(8'h50, 1'b0);
        chk(16'h0000, rd_q & 16'h0008, 8'h50);
        wr(8'h18, 16'h0000);
        wr(8'h19, 16'h8000);
        wr(8'h1E, 16'hFFF0);
        wr(8'h50, 16'h0003);
        wr(8'h1A, 16'h4000);
        wr(8'h1B, 16'hFFF0);
        wr(8'h1C, 16'h8000);
        wr(8'h1F, 16'h8000);
        ovx = 12'h000;
        uvx = 12'h000;
        // Two scans: global hot enable off then on, prompt then slow
        for (p = 0; p < 2; p = p + 1) begin
            seed = xs(seed);
            en = seed[11:0] | 12'h001;
            base <= seed[27:16];
            slow <= p[0];
            cfg = p[0] ? 16'h003F : 16'h001F;
            starts = 0;
            wr(8'h61, {4'h0, en});
            wr(8'h60, cfg);
            wr(8'h60, cfg);
            i = 0;
            while (scan_busy !== 1'b0 && i < 3000) begin
                @(posedge clk_sys);
                #1;
                i = i + 1;
            end
            chk(16'h0000, {15'h0000, scan_busy}, 8'h60);
            sum = 0;
            hi = 0;
            lo = 4095;
            n = 0;
            for (i = 0; i < 12; i = i + 1) begin
                c = base ^ {3{i[3:0]}};
                rd(8'h40 + i[7:0], 1'b0);
                if (en[i]) begin
                    n = n + 1;
                    sum = sum + c;
                    hi = (c > hi) ? c : hi;
                    lo = (c < lo) ? c : lo;
                    ovx[i] = ovx[i] | (c > 12'h800);
                    uvx[i] = uvx[i] | (c < 12'h400);
                    chk({c, 4'h0}, rd_q, 8'h40 + i[7:0]);
                end
            end
            chk(n[15:0] + 16'h0003, starts[15:0], 8'h60);
            rd(8'h4C, 1'b0);
            chk(sum[15:0], rd_q, 8'h4C);
            rd(8'h4D, 1'b0);
            chk({hi[11:0], 4'h0}, rd_q, 8'h4D);
            rd(8'h4E, 1'b0);
            chk({lo[11:0], 4'h0}, rd_q, 8'h4E);
            rd(8'h50, 1'b0);
            chk({base ^ 12'hCCC, 4'hB}, rd_q, 8'h50);
            rd(8'h51, 1'b0);
            chk({base ^ 12'hDDD, 4'h8}, rd_q, 8'h51);
            rd(8'h52, 1'b0);
            chk({base ^ 12'hEEE, 4'h8}, rd_q, 8'h52);
            rd(8'h64, 1'b0);
            chk({4'h0, ovx}, rd_q, 8'h64);
            rd(8'h65, 1'b0);
            chk({4'h0, uvx}, rd_q, 8'h65);
            rd(8'h66, 1'b0);
            chk({13'h0000, ((hi - lo) > 2048),
                ((base ^ 12'hCCC) >= 12'h800), p[0]}, rd_q, 8'h66);
        end
        end_of_test;
    end
endmodule // testbench

bind ctrb_top ctrb_chk i_chk (.clk_sys(clk_sys), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .check_byte_q(check_byte_q),
    .rd_valid_q(rd_valid_q), .pec_error(pec_error),
    .adc_start_q(adc_start_q), .adc_chan_q(adc_chan_q),
    .scan_busy(scan_busy));
